// *** common/port_cfg_pkg.sv ***
package port_cfg_pkg;
  // register byte offsets on the apb window
  localparam logic [7:0] OFS_DIG_IN_REG = 8'h00;
  localparam logic [7:0] OFS_RDRV_REG   = 8'h04;
  localparam logic [7:0] OFS_RSVD_REG   = 8'h08;
  localparam logic [7:0] OFS_POL_REG    = 8'h0C;
  localparam logic [7:0] OFS_OCPE_REG   = 8'h10;
  localparam logic [7:0] OFS_OCIE_REG   = 8'h14;
  localparam logic [7:0] OFS_OCFLAG_REG = 8'h18;
  localparam logic [7:0] OFS_FRSEL_REG  = 8'h1C;
  localparam logic [7:0] OFS_IRQST_REG  = 8'h20;
  localparam logic [7:0] OFS_IRQMSK_REG = 8'h24;

  localparam int        PORT_W       = 8;
  localparam int        OC_BIT       = 2;
  localparam int        FAULT_BIT    = 2;
  localparam logic [7:0] RST_DIG_IN  = 8'h00;
  localparam logic [7:0] RST_RDRV    = 8'h00;
  localparam logic [7:0] RST_POL     = 8'h00;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  // irq status layout: bit 0 over-current event
  localparam int        IRQ_OC_BIT   = 0;
endpackage : port_cfg_pkg

// *** hw/port_pin_config.sv ***
`timescale 1ns/1ns
module port_pin_config (
  input  wire logic        i_ref_clk,        // 100 mhz bus clock
  input  wire logic        i_sys_rst,        // sync reset, active high
  input  wire logic        i_psel,           // apb select
  input  wire logic        i_penable,        // apb access phase
  input  wire logic        i_pwrite,         // apb write
  input  wire logic [7:0]  i_paddr,          // apb byte address
  input  wire logic [31:0] i_pwdata,         // apb write data
  output logic      [31:0] o_prdata,         // apb read data
  output logic             o_pready,         // apb ready
  output logic             o_pslverr,        // apb error, unmapped
  input  wire logic [7:0]  i_dir_out,        // per pin: 1 output
  input  wire logic [7:0]  i_periph_dig_use, // per pin: peripheral digital use
  input  wire logic        i_oc_detect,      // raw over-current comparator pin t2
  input  wire logic        i_pin_t2,         // port t pin two level
  output logic      [7:0]  o_input_buf_en,   // input buffer enable
  output logic      [7:0]  o_reduced_drive,  // reduced drive per pin
  output logic      [7:0]  o_pull_down_sel,  // 1 pulldown, 0 pullup
  output logic      [7:0]  o_rise_edge_sel,  // 1 rising, 0 falling edge
  output logic             o_oc_detector_en, // over-current detector enable
  output logic             o_oc_irq,         // over-current request
  output logic             o_fault_five,     // fault five to pwm, active high
  output logic             o_irq             // summary interrupt, level
);

  typedef struct packed {
    logic [7:0]  dig_in;
    logic [7:0]  rdrv;
    logic [7:0]  pol;
    logic        ocpe;
    logic        ocie;
    logic        ocflag;
    logic        frsel;
    logic        irq_st;
    logic        irq_msk;
    logic [2:0]  oc_sync;
    logic [2:0]  t2_sync;
    logic        oc_stable;
    logic        t2_stable;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  buf_en;
    logic [7:0]  red_drv;
    logic [7:0]  pd_sel;
    logic        det_en;
    logic        oc_irq;
    logic        pwm_fault_input_five;
    logic        irq;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] ofs);
    is_ofs = (a == ofs);
  endfunction : is_ofs

  function automatic logic [31:0] pad8(input logic [7:0] v);
    pad8 = {24'h000000, v};
  endfunction : pad8

  logic        wr_acc;
  logic        rd_acc;
  logic        oc_event;
  logic        hit;
  logic [31:0] rd_val;

  always_comb begin
    wr_acc = i_psel & i_penable & i_pwrite & ~st_ff.pready;
    rd_acc = i_psel & i_penable & ~i_pwrite & ~st_ff.pready;
    nxt_st = st_ff;

    // three-stage sync; a change counts once stages two and three agree
    nxt_st.oc_sync = {st_ff.oc_sync[1:0], i_oc_detect};
    nxt_st.t2_sync = {st_ff.t2_sync[1:0], i_pin_t2};
    if (st_ff.oc_sync[2] == st_ff.oc_sync[1]) begin
      nxt_st.oc_stable = st_ff.oc_sync[2];
    end
    if (st_ff.t2_sync[2] == st_ff.t2_sync[1]) begin
      nxt_st.t2_stable = st_ff.t2_sync[2];
    end

    // detection only counts while the detector is enabled
    oc_event = st_ff.ocpe & st_ff.oc_stable;

    hit = 1'b1;
    rd_val = 32'h00000000;
    case (1'b1)
      is_ofs(i_paddr, port_cfg_pkg::OFS_DIG_IN_REG): rd_val = pad8(st_ff.dig_in);
      is_ofs(i_paddr, port_cfg_pkg::OFS_RDRV_REG):   rd_val = pad8(st_ff.rdrv);
      is_ofs(i_paddr, port_cfg_pkg::OFS_RSVD_REG):   rd_val = pad8(port_cfg_pkg::RST_ZERO);
      is_ofs(i_paddr, port_cfg_pkg::OFS_POL_REG):    rd_val = pad8(st_ff.pol);
      is_ofs(i_paddr, port_cfg_pkg::OFS_OCPE_REG):
        rd_val[port_cfg_pkg::OC_BIT] = st_ff.ocpe;
      is_ofs(i_paddr, port_cfg_pkg::OFS_OCIE_REG):
        rd_val[port_cfg_pkg::OC_BIT] = st_ff.ocie;
      is_ofs(i_paddr, port_cfg_pkg::OFS_OCFLAG_REG):
        rd_val[port_cfg_pkg::OC_BIT] = st_ff.ocflag;
      is_ofs(i_paddr, port_cfg_pkg::OFS_FRSEL_REG):  rd_val[0] = st_ff.frsel;
      is_ofs(i_paddr, port_cfg_pkg::OFS_IRQST_REG):
        rd_val[port_cfg_pkg::IRQ_OC_BIT] = st_ff.irq_st;
      is_ofs(i_paddr, port_cfg_pkg::OFS_IRQMSK_REG):
        rd_val[port_cfg_pkg::IRQ_OC_BIT] = st_ff.irq_msk;
      default: hit = 1'b0;
    endcase

    // one wait state: ready rises the cycle after the access phase starts
    nxt_st.pready  = rd_acc | wr_acc;
    nxt_st.pslverr = (rd_acc | wr_acc) & ~hit;
    nxt_st.prdata  = rd_acc ? rd_val : 32'h00000000;

    if (wr_acc) begin
      case (1'b1)
        is_ofs(i_paddr, port_cfg_pkg::OFS_DIG_IN_REG): nxt_st.dig_in = i_pwdata[7:0];
        is_ofs(i_paddr, port_cfg_pkg::OFS_RDRV_REG): nxt_st.rdrv = i_pwdata[7:0];
        is_ofs(i_paddr, port_cfg_pkg::OFS_POL_REG):  nxt_st.pol  = i_pwdata[7:0];
        is_ofs(i_paddr, port_cfg_pkg::OFS_OCPE_REG):
          nxt_st.ocpe = i_pwdata[port_cfg_pkg::OC_BIT];
        is_ofs(i_paddr, port_cfg_pkg::OFS_OCIE_REG):
          nxt_st.ocie = i_pwdata[port_cfg_pkg::OC_BIT];
        is_ofs(i_paddr, port_cfg_pkg::OFS_FRSEL_REG): nxt_st.frsel = i_pwdata[0];
        is_ofs(i_paddr, port_cfg_pkg::OFS_IRQMSK_REG):
          nxt_st.irq_msk = i_pwdata[port_cfg_pkg::IRQ_OC_BIT];
        default: ; // reserved and unmapped writes discarded
      endcase
    end

    // write-one clear; a same-cycle event wins over the clear
    if (wr_acc && is_ofs(i_paddr, port_cfg_pkg::OFS_OCFLAG_REG)
        && i_pwdata[port_cfg_pkg::OC_BIT]) begin
      nxt_st.ocflag = 1'b0;
    end
    if (oc_event) begin
      nxt_st.ocflag = 1'b1;
    end
    if (wr_acc && is_ofs(i_paddr, port_cfg_pkg::OFS_IRQST_REG)
        && i_pwdata[port_cfg_pkg::IRQ_OC_BIT]) begin
      nxt_st.irq_st = 1'b0;
    end
    if (oc_event) begin
      nxt_st.irq_st = 1'b1;
    end

    // outputs from registered config
    nxt_st.buf_en  = st_ff.dig_in | i_periph_dig_use;
    nxt_st.red_drv = st_ff.rdrv & i_dir_out;
    nxt_st.pd_sel  = st_ff.pol;
    nxt_st.det_en  = st_ff.ocpe;
    nxt_st.oc_irq  = st_ff.ocflag & st_ff.ocie;
    // normalise to active high: low polarity inverts the pin level
    nxt_st.pwm_fault_input_five  = st_ff.frsel &
                     (st_ff.t2_stable ~^ st_ff.pol[port_cfg_pkg::FAULT_BIT]);
    nxt_st.irq     = st_ff.irq_st & st_ff.irq_msk;

    if (i_sys_rst) begin
      nxt_st         = '0;
      nxt_st.dig_in  = port_cfg_pkg::RST_DIG_IN;
      nxt_st.rdrv    = port_cfg_pkg::RST_RDRV;
      nxt_st.pol     = port_cfg_pkg::RST_POL;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    st_ff <= nxt_st;
  end

  assign o_prdata         = st_ff.prdata;
  assign o_pready         = st_ff.pready;
  assign o_pslverr        = st_ff.pslverr;
  assign o_input_buf_en   = st_ff.buf_en;
  assign o_reduced_drive  = st_ff.red_drv;
  assign o_pull_down_sel  = st_ff.pd_sel;
  assign o_rise_edge_sel  = st_ff.pd_sel;
  assign o_oc_detector_en = st_ff.det_en;
  assign o_oc_irq         = st_ff.oc_irq;
  assign o_fault_five     = st_ff.pwm_fault_input_five;
  assign o_irq            = st_ff.irq;

endmodule : port_pin_config

// *** tb/port_pin_config_assertions.sv ***
`timescale 1ns/1ns
module port_pin_config_assertions (
  input wire logic        i_ref_clk, i_sys_rst, i_psel, i_penable, i_pwrite, // apb
  input wire logic [7:0]  i_paddr, i_dir_out, i_periph_dig_use, // address, pin inputs
  input wire logic [31:0] o_prdata,                             // read data
  input wire logic        o_pready, o_pslverr,                  // apb answer
  input wire logic [7:0]  o_input_buf_en, o_reduced_drive, o_pull_down_sel, o_rise_edge_sel
);
  wire acc = i_psel && i_penable && !o_pready;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  a_ready_one_wait: assert property (acc |=> o_pready) else $error("ready late");
  a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready held");
  a_periph_forces_buf: assert property (!$past(i_sys_rst) |->
    (o_input_buf_en & $past(i_periph_dig_use)) == $past(i_periph_dig_use)) else $error("buf off");
  a_input_no_rdrv: assert property (!$past(i_sys_rst) |->
    (o_reduced_drive & ~$past(i_dir_out)) == 8'h00) else $error("rdrv on input");
  a_pull_edge_pair: assert property (o_pull_down_sel == o_rise_edge_sel) else $error("pol");
  a_rsvd_reads_zero: assert property (acc && !i_pwrite && i_paddr == 8'h08
    |=> o_prdata == 32'h0 && !o_pslverr) else $error("reserved read");
  a_unmapped_error: assert property (acc |=> o_pslverr ==
    (($past(i_paddr) > 8'h24) || ($past(i_paddr[1:0]) != 2'b00)))
    else $error("slverr");
  a_idle_data_zero: assert property (!o_pready |-> o_prdata == 32'h0) else $error("data");
endmodule : port_pin_config_assertions
bind port_pin_config port_pin_config_assertions u_chk (.i_ref_clk, .i_sys_rst, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_dir_out, .i_periph_dig_use, .o_prdata, .o_pready,
  .o_pslverr, .o_input_buf_en, .o_reduced_drive, .o_pull_down_sel, .o_rise_edge_sel);

// *** tb/port_pin_config_tb_top.sv ***
`timescale 1ns/1ns
module port_pin_config_tb_top;
  logic        i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, i_oc_detect = 1'b0, i_pin_t2 = 1'b0, rerr;
  logic [7:0]  i_paddr = 8'h00, i_dir_out = 8'h00, i_periph_dig_use = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rdat;
  logic        o_pready, o_pslverr, o_oc_detector_en, o_oc_irq, o_fault_five, o_irq;
  logic [7:0]  o_input_buf_en, o_reduced_drive, o_pull_down_sel, o_rise_edge_sel;
  int          fail_count = 0, check_count = 0, cycles = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  port_pin_config u_dut (.*);
  task wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // entered just after an edge; one idle cycle between transfers
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= wr; i_paddr <= a; i_pwdata <= d;
    @(posedge i_ref_clk) i_penable <= 1'b1;
    @(posedge i_ref_clk);
    while (o_pready !== 1'b1) @(posedge i_ref_clk);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0; i_penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    for (int a = 0; a < 'h28; a += 4) rd(a[7:0], 32'h0);
    $display("test reset values done");
    i_dir_out <= 8'h0F; i_periph_dig_use <= 8'h30;
    apb(1, 8'h00, 32'h0F); apb(1, 8'h04, 32'hA5); apb(1, 8'h0C, 32'hA5); apb(1, 8'h08, 32'hFF);
    rd(8'h04, 32'hA5);
    rd(8'h0C, 32'hA5);
    rd(8'h08, 32'h0);
    rd(8'h40, 32'h0); chk(rerr, 1);
    chk(o_input_buf_en, 8'h3F);
    chk(o_reduced_drive, 8'h05);
    chk(o_pull_down_sel, 8'hA5); chk(o_rise_edge_sel, 8'hA5);
    apb(1, 8'h00, 32'h0E);
    repeat (1) @(posedge i_ref_clk);
    chk(o_input_buf_en, 8'h3E);
    $display("test pin config done");
    apb(1, 8'h1C, 32'h1); repeat (6) @(posedge i_ref_clk);
    chk(o_fault_five, 0);
    i_pin_t2 <= 1'b1; repeat (6) @(posedge i_ref_clk);
    chk(o_fault_five, 1);
    apb(1, 8'h0C, 32'hA1); repeat (2) @(posedge i_ref_clk);
    chk(o_fault_five, 0); chk(o_pull_down_sel, 8'hA1);
    $display("test fault level done");
    apb(1, 8'h10, 32'h4); repeat (2) @(posedge i_ref_clk);
    chk(o_oc_detector_en, 1);
    i_oc_detect <= 1'b1; repeat (8) @(posedge i_ref_clk);
    rd(8'h18, 32'h4); chk(o_oc_irq, 0); chk(o_irq, 0);
    apb(1, 8'h14, 32'h4); apb(1, 8'h24, 32'h1); repeat (2) @(posedge i_ref_clk);
    chk(o_oc_irq, 1); chk(o_irq, 1);
    i_oc_detect <= 1'b0; repeat (8) @(posedge i_ref_clk);
    apb(1, 8'h18, 32'h0); rd(8'h18, 32'h4);
    apb(1, 8'h18, 32'h4); apb(1, 8'h20, 32'h1); repeat (2) @(posedge i_ref_clk);
    rd(8'h18, 32'h0); chk(o_oc_irq, 0); chk(o_irq, 0);
    apb(1, 8'h10, 32'h0);
    i_oc_detect <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    rd(8'h18, 32'h0);
    chk(o_oc_detector_en, 0);
    $display("test over-current done");
    wrap_up();
  end
endmodule : port_pin_config_tb_top
